// ### hdl/tef_pkg.sv
// Package with register map, field layouts, reset values and types of the timer event-flag block.
package tef_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses on the APB bus)
    // ------------------------------------------------------------------
    localparam int         TEF_AW          = 8;
    localparam int         TEF_NCH         = 2;
    localparam logic [7:0] TEF_OFF_MAIN    = 8'h00;
    localparam logic [7:0] TEF_OFF_COUNT   = 8'h04;
    localparam logic [7:0] TEF_OFF_MOD     = 8'h08;
    localparam logic [7:0] TEF_OFF_CH_CTL  = 8'h0C;
    localparam logic [7:0] TEF_OFF_CH_VAL  = 8'h10;
    localparam logic [7:0] TEF_CH_STRIDE   = 8'h08;

    // ------------------------------------------------------------------
    // Counter constants and field positions
    // ------------------------------------------------------------------
    localparam logic [15:0] TEF_CNT_ALL_ONES  = 16'hFFFF;
    localparam logic [15:0] TEF_CNT_ZERO      = 16'h0000;
    localparam logic [15:0] TEF_CNT_ONE       = 16'h0001;
    localparam logic [15:0] TEF_MOD_RST       = 16'h0000;
    localparam logic [15:0] TEF_VAL_RST       = 16'h0000;
    localparam int          TEF_MAIN_FLAG_BIT = 4;
    localparam int          TEF_CH_FLAG_BIT   = 5;
    localparam logic [1:0]  TEF_CLK_STOPPED   = 2'b00;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        TEF_MODE_CAPTURE = 2'b00,
        TEF_MODE_COMPARE = 2'b01,
        TEF_MODE_EPWM    = 2'b10,
        TEF_MODE_EPWM2   = 2'b11
    } tef_mode_e;

    typedef enum logic [1:0] {
        TEF_EDGE_OFF  = 2'b00,
        TEF_EDGE_RISE = 2'b01,
        TEF_EDGE_FALL = 2'b10,
        TEF_EDGE_ANY  = 2'b11
    } tef_edge_e;

    typedef enum logic {
        TEF_DIR_UP   = 1'b0,
        TEF_DIR_DOWN = 1'b1
    } tef_dir_e;

    // Main control word, bits [4:0] of the register.
    typedef struct packed {
        logic       overflow_flag;
        logic       overflow_irq_enable;
        logic       center_align_select;
        logic [1:0] clock_select;
    } tef_main_s;

    // Channel control word, bits [5:0] of the register.
    typedef struct packed {
        logic      channel_event_flag;
        logic      channel_irq_enable;
        tef_mode_e mode;
        tef_edge_e edge_level_select;
    } tef_chctl_s;

    localparam tef_main_s  TEF_MAIN_RST  = 5'h00;
    localparam tef_chctl_s TEF_CHCTL_RST = 6'h00;

endpackage

// ### hdl/tef_top.sv
// Event-flag logic of a 16-bit timer/PWM unit with an APB register slave.
//
// Overview of operation
// [R1] Free-running: overflow flag on all-ones to zero.
// [R2] Not centred: overflow flag on modulo-to-zero wrap.
// [R3] Centred: overflow flag at modulo, direction reversal.
// [R4] Capture: edge select chooses none/rise/fall/any.
// [R5] Compare: flag whenever the running counter equals channel value.
// [R6] Edge PWM: flag once per period at match.
// [R7] Centre PWM: flag at up and down match.
// [R8] Clear by read-while-set then write zero.
// [R9] Level high interrupt when enable and flag set.
// [R10] Reset clears control, channels become released captures.
// [R11] Capture inputs synchronised before edge detection.
`timescale 1ns/1ps
module tef_top (
    // Clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // APB slave
    input  wire logic [tef_pkg::TEF_AW-1:0] paddr,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // Channel pins
    input  wire logic [tef_pkg::TEF_NCH-1:0] cap_in,
    output logic      [tef_pkg::TEF_NCH-1:0] ch_out,
    output logic      [tef_pkg::TEF_NCH-1:0] ch_oe,
    // Interrupt requests
    output logic                            irq_overflow,
    output logic      [tef_pkg::TEF_NCH-1:0] irq_channel
);
    import tef_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------

    // Address of a channel register: base plus stride per channel.
    function automatic logic [7:0] ch_addr(input logic [7:0] base, input int idx);
        logic [7:0] step;
        step = TEF_CH_STRIDE * 8'(idx);
        return base + step;
    endfunction

    // Edge qualifier for the synchronised capture input.
    function automatic logic edge_hit(input tef_edge_e sel, input logic prev, input logic cur);
        logic res;
        res = 1'b0;
        case (sel)
            TEF_EDGE_RISE: res = !prev && cur;
            TEF_EDGE_FALL: res = prev && !cur;
            TEF_EDGE_ANY:  res = prev != cur;
            default:       res = 1'b0;
        endcase
        return res;
    endfunction

    // Two-step flag clear; returns {flag, armed}. A new event always wins over the clear.
    function automatic logic [1:0] flag_upd(input logic flag, input logic arm, input logic ev,
                                            input logic rd_set, input logic wr,
                                            input logic wbit);
        logic nflag;
        logic narm;
        nflag = ev || (flag && !(arm && wr && !wbit)); // R8
        narm  = arm;
        if (ev || wr) begin
            narm = 1'b0; // R8
        end else if (rd_set) begin
            narm = 1'b1; // R8
        end
        return {nflag, narm};
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tef_main_s                 main_q,   main_d;
    logic       [15:0]         cnt_q,    cnt_d;
    logic       [15:0]         mod_q,    mod_d;
    tef_dir_e                  dir_q,    dir_d;
    tef_chctl_s [TEF_NCH-1:0]  ch_q,     ch_d;
    logic       [TEF_NCH-1:0][15:0] val_q, val_d;
    logic                      arm_ov_q, arm_ov_d;
    logic       [TEF_NCH-1:0]  arm_ch_q, arm_ch_d;
    logic       [TEF_NCH-1:0]  out_q,    out_d;
    logic       [31:0]         prdata_q, prdata_d;
    logic       [TEF_NCH-1:0]  sync1_q;
    logic       [TEF_NCH-1:0]  sync2_q;
    logic       [TEF_NCH-1:0]  sync3_q;

    logic acc_wr;
    logic acc_rd;
    logic setup;
    logic mapped;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------

    // Read data is latched in the setup cycle, so every access completes with no wait state.
    assign setup   = psel && !penable;
    assign acc_wr  = psel && penable && pwrite;
    assign acc_rd  = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_q;

    // Address decode and read multiplexer.
    always_comb begin
        logic [31:0] rd;
        rd     = 32'h0000_0000;
        mapped = 1'b1;
        if (paddr == TEF_OFF_MAIN) begin
            rd = {27'h0000000, main_q};
        end else if (paddr == TEF_OFF_COUNT) begin
            rd = {16'h0000, cnt_q};
        end else if (paddr == TEF_OFF_MOD) begin
            rd = {16'h0000, mod_q};
        end else if (paddr == ch_addr(TEF_OFF_CH_CTL, 0)) begin
            rd = {26'h0000000, ch_q[0]};
        end else if (paddr == ch_addr(TEF_OFF_CH_VAL, 0)) begin
            rd = {16'h0000, val_q[0]};
        end else if (paddr == ch_addr(TEF_OFF_CH_CTL, 1)) begin
            rd = {26'h0000000, ch_q[1]};
        end else if (paddr == ch_addr(TEF_OFF_CH_VAL, 1)) begin
            rd = {16'h0000, val_q[1]};
        end else begin
            mapped = 1'b0;
        end
        prdata_d = setup ? rd : prdata_q;
    end

    // ------------------------------------------------------------------
    // Counter, flags, channels and pins
    // ------------------------------------------------------------------

    // Next state of the whole timer. Software writes take effect at the access edge only.
    always_comb begin
        logic        running;
        logic        centre;
        logic        ov_ev;
        logic [15:0] term;
        logic [1:0]  upd;
        logic        ch_ev;
        logic        match;
        logic        capture;
        main_d   = main_q;
        cnt_d    = cnt_q;
        mod_d    = mod_q;
        dir_d    = dir_q;
        ch_d     = ch_q;
        val_d    = val_q;
        arm_ov_d = arm_ov_q;
        arm_ch_d = arm_ch_q;
        out_d    = out_q;
        ov_ev    = 1'b0;
        upd      = 2'b00;
        ch_ev    = 1'b0;
        match    = 1'b0;
        capture  = 1'b0;
        running  = main_q.clock_select != TEF_CLK_STOPPED;
        centre   = main_q.center_align_select;
        // A zero modulo means the counter runs free through all-ones.
        term     = (mod_q == TEF_CNT_ZERO) ? TEF_CNT_ALL_ONES : mod_q;

        // Main counter and overflow event.
        if (running) begin
            if (centre) begin
                if (dir_q == TEF_DIR_UP) begin
                    if (cnt_q == mod_q) begin
                        dir_d = TEF_DIR_DOWN;
                        cnt_d = cnt_q - TEF_CNT_ONE;
                        ov_ev = 1'b1; // R3
                    end else begin
                        cnt_d = cnt_q + TEF_CNT_ONE;
                    end
                end else if (cnt_q == TEF_CNT_ZERO) begin
                    dir_d = TEF_DIR_UP;
                    cnt_d = TEF_CNT_ONE;
                end else begin
                    cnt_d = cnt_q - TEF_CNT_ONE;
                end
            end else begin
                dir_d = TEF_DIR_UP;
                if (cnt_q == term) begin
                    cnt_d = TEF_CNT_ZERO;
                    ov_ev = 1'b1; // R1 R2
                end else begin
                    cnt_d = cnt_q + TEF_CNT_ONE;
                end
            end
        end

        // Software writes to the main, count and modulo registers.
        if (acc_wr && paddr == TEF_OFF_MAIN) begin
            main_d = tef_main_s'(pwdata[4:0]);
        end
        if (acc_wr && (paddr == TEF_OFF_MAIN || paddr == TEF_OFF_COUNT)) begin
            cnt_d = TEF_CNT_ZERO;
            dir_d = TEF_DIR_UP;
        end
        if (acc_wr && paddr == TEF_OFF_MOD) begin
            mod_d = pwdata[15:0];
        end
        upd = flag_upd(main_q.overflow_flag, arm_ov_q, ov_ev,
                       acc_rd && paddr == TEF_OFF_MAIN && prdata_q[TEF_MAIN_FLAG_BIT],
                       acc_wr && paddr == TEF_OFF_MAIN, pwdata[TEF_MAIN_FLAG_BIT]);
        main_d.overflow_flag = upd[1];
        arm_ov_d             = upd[0];

        // Channels: in centred operation every channel acts as centre PWM.
        for (int i = 0; i < TEF_NCH; i++) begin
            match   = running && cnt_q == val_q[i];
            capture = !centre && ch_q[i].mode == TEF_MODE_CAPTURE;
            if (capture) begin
                ch_ev = edge_hit(ch_q[i].edge_level_select, sync3_q[i], sync2_q[i]); // R4 R11
                if (ch_ev) begin
                    val_d[i] = cnt_q;
                end
            end else begin
                ch_ev = match; // R5 R6 R7
            end
            // Pin level: compare toggles, edge PWM starts at wrap, centre PWM follows direction.
            if (centre) begin
                if (match) begin
                    out_d[i] = (dir_q == TEF_DIR_UP) ? ch_q[i].edge_level_select[0]
                                                     : !ch_q[i].edge_level_select[0];
                end
            end else if (ch_q[i].mode == TEF_MODE_COMPARE) begin
                if (match) begin
                    out_d[i] = !out_q[i];
                end
            end else if (!capture) begin
                if (match) begin
                    out_d[i] = ch_q[i].edge_level_select[0];
                end else if (ov_ev) begin
                    out_d[i] = !ch_q[i].edge_level_select[0];
                end
            end
            if (acc_wr && paddr == ch_addr(TEF_OFF_CH_CTL, i)) begin
                ch_d[i] = tef_chctl_s'(pwdata[5:0]);
            end
            if (acc_wr && paddr == ch_addr(TEF_OFF_CH_VAL, i)) begin
                val_d[i] = pwdata[15:0];
            end
            upd = flag_upd(ch_q[i].channel_event_flag, arm_ch_q[i], ch_ev,
                           acc_rd && paddr == ch_addr(TEF_OFF_CH_CTL, i)
                               && prdata_q[TEF_CH_FLAG_BIT],
                           acc_wr && paddr == ch_addr(TEF_OFF_CH_CTL, i),
                           pwdata[TEF_CH_FLAG_BIT]);
            ch_d[i].channel_event_flag = upd[1];
            arm_ch_d[i]                = upd[0];
        end
    end

    // Registers of the timer; reset stops the clock and releases every pin.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_q   <= TEF_MAIN_RST; // R10
            cnt_q    <= TEF_CNT_ZERO;
            mod_q    <= TEF_MOD_RST;
            dir_q    <= TEF_DIR_UP;
            ch_q     <= {TEF_NCH{TEF_CHCTL_RST}}; // R10
            val_q    <= {TEF_NCH{TEF_VAL_RST}};
            arm_ov_q <= 1'b0;
            arm_ch_q <= '0;
            out_q    <= '0;
            prdata_q <= 32'h0000_0000;
        end else begin
            main_q   <= main_d;
            cnt_q    <= cnt_d;
            mod_q    <= mod_d;
            dir_q    <= dir_d;
            ch_q     <= ch_d;
            val_q    <= val_d;
            arm_ov_q <= arm_ov_d;
            arm_ch_q <= arm_ch_d;
            out_q    <= out_d;
            prdata_q <= prdata_d;
        end
    end

    // Capture synchroniser; the edge detector looks only at stages two and three.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
            sync3_q <= '0;
        end else begin
            sync1_q <= cap_in; // R11
            sync2_q <= sync1_q;
            sync3_q <= sync2_q;
        end
    end

    // ------------------------------------------------------------------
    // Pins and interrupt requests
    // ------------------------------------------------------------------

    // A pin is driven only by an output function with a level selected.
    always_comb begin
        for (int i = 0; i < TEF_NCH; i++) begin
            ch_oe[i] = (main_q.center_align_select || ch_q[i].mode != TEF_MODE_CAPTURE)
                       && ch_q[i].edge_level_select != TEF_EDGE_OFF; // R10
            irq_channel[i] = ch_q[i].channel_irq_enable && ch_q[i].channel_event_flag; // R9
        end
    end

    assign ch_out       = out_q;
    assign irq_overflow = main_q.overflow_irq_enable && main_q.overflow_flag; // R9

endmodule

// ### tb/tb.sv
// Self-checking testbench of the timer event-flag block.
`timescale 1ns/1ps
module tb;
    import tef_pkg::*;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00, ovf_rises, ch_rises;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic        pready, pslverr, e, irq_overflow;
    logic [1:0]  cap_in = 2'b00, ch_out, ch_oe, irq_channel;
    int          miscompares = 0, n_tests = 0, cyc = 0;
    localparam logic [7:0] C0 = TEF_OFF_CH_CTL, C1 = TEF_OFF_CH_CTL + TEF_CH_STRIDE;
    localparam logic [7:0] M = TEF_OFF_MAIN, V1 = TEF_OFF_CH_VAL + TEF_CH_STRIDE;

    tef_top tef_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .cap_in(cap_in), .ch_out(ch_out),
        .ch_oe(ch_oe), .irq_overflow(irq_overflow), .irq_channel(irq_channel));
    tef_irq_sink tef_irq_sink_i (.pclk(pclk), .presetn(presetn), .irq_overflow(irq_overflow),
        .irq_channel(irq_channel), .ovf_rises_q(ovf_rises), .ch_rises_q(ch_rises));

    // Clock, and a ceiling well above the long free-running wait.
    always #20 pclk = ~pclk;
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            miscompares++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer; request held until pready is seen high.
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= w; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d); apb(a, 1'b1, d); endtask
    task automatic rd(input logic [7:0] a); apb(a, 1'b0, 32'h0); endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_capture();
        for (int s = 0; s < 4; s++) begin
            rd(C0);
            wr(C0, 32'(s));
            cap_in[0] <= 1'b1;
            repeat (6) @(posedge pclk);
            rd(C0); chk("rise flag", r[5], s[0]);
            wr(C0, 32'(s));
            cap_in[0] <= 1'b0;
            repeat (6) @(posedge pclk);
            rd(C0); chk("fall flag", r[5], s[1]);
            wr(C0, 32'(s));
        end
    endtask
    task automatic t_modulo();
        wr(TEF_OFF_MOD, 32'd9); rd(M); wr(M, 32'h09);
        rd(M); chk("ovf early", r[4], 1'b0);
        repeat (10) @(posedge pclk);
        rd(M); chk("ovf wrap", r[4], 1'b1);
        chk("ovf irq", irq_overflow, 1'b1);
        wr(M, 32'h09);
        rd(M); chk("ovf cleared", r[4], 1'b0);
        chk("ovf irq off", irq_overflow, 1'b0);
        repeat (8) @(posedge pclk);
        rd(M);
        repeat (12) @(posedge pclk);
        wr(M, 32'h09);
        rd(M); chk("ovf kept", r[4], 1'b1);
        chk("irq seen", ovf_rises != 8'h00, 1'b1);
    endtask
    task automatic t_channels();
        wr(M, 32'h0); wr(TEF_OFF_CH_VAL, 32'd5); wr(V1, 32'd3);
        wr(C0, 32'h14); wr(C1, 32'h09); wr(M, 32'h01);
        repeat (12) @(posedge pclk);
        rd(C0); chk("compare flag", r[5], 1'b1);
        chk("compare irq", irq_channel[0], 1'b1);
        rd(C1); chk("pwm flag", r[5], 1'b1);
        chk("pin enables", ch_oe, 2'b10);
        chk("pwm pin high", ch_out[1], 1'b1);
        chk("ch irq seen", ch_rises != 8'h00, 1'b1);
        wr(C0, 32'h1D);
        @(posedge pclk);
        chk("pwm pin low", ch_out[1], 1'b0);
        chk("pin enables mode3", ch_oe, 2'b11);
    endtask
    task automatic t_centre();
        wr(M, 32'h0); rd(C0); wr(C0, 32'h1D); wr(TEF_OFF_MOD, 32'd20);
        chk("ch irq off", irq_channel[0], 1'b0);
        rd(C1); wr(C1, 32'h09); wr(V1, 32'd6);
        rd(M); wr(M, 32'h07);
        rd(M); chk("centre early", r[4], 1'b0);
        repeat (10) @(posedge pclk);
        rd(C1); chk("up match", r[5], 1'b1);
        chk("centre pin up", ch_out[1], 1'b1);
        wr(C1, 32'h09);
        rd(C1); chk("cleared", r[5], 1'b0);
        repeat (20) @(posedge pclk);
        rd(C1); chk("down match", r[5], 1'b1);
        chk("centre pin down", ch_out[1], 1'b0);
        rd(M); chk("centre ovf", r[4], 1'b1);
    endtask
    task automatic t_free();
        wr(M, 32'h0); wr(TEF_OFF_MOD, 32'h0); rd(M); wr(M, 32'h02);
        repeat (65520) @(posedge pclk);
        rd(M); chk("free early", r[4], 1'b0);
        repeat (40) @(posedge pclk);
        rd(M); chk("free wrap", r[4], 1'b1);
    endtask
    task automatic t_end();
        rd(8'h1C); chk("unmapped err", e, 1'b1);
        chk("unmapped data", r, 32'h0);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(M); chk("main after reset", r, 32'h0);
        chk("pins after reset", ch_oe, 2'b00);
    endtask

    // Main sequence: reset, scenarios, verdict.
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(M); chk("main reset", r, 32'h0);
        rd(C0); chk("ctl reset", r, 32'h0);
        t_capture();
        t_modulo();
        t_channels();
        t_centre();
        t_free();
        t_end();
        close_out();
    end
endmodule

// ### tb/tef_chk.sv
// Checker with the port-level properties of the timer event-flag block.
`timescale 1ns/1ps
module tef_chk (
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic [7:0]  paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Pins and requests
    input wire logic [1:0]  ch_oe,
    input wire logic        irq_overflow,
    input wire logic [1:0]  irq_channel
);
    // ------------------------------------------------------------
    // Bus properties
    // ------------------------------------------------------------
    ready_high_a: assert property (@(posedge pclk) disable iff (!presetn) pready)
        else $error("pready low");
    slverr_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && penable) |-> !pslverr) else $error("pslverr outside access");
    slverr_map_a: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && paddr == 8'h1C |-> pslverr) else $error("unmapped not refused");
    rdata_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        !(psel && !penable) |=> $stable(prdata)) else $error("prdata moved");
    // ------------------------------------------------------------
    // Requests and pins: only a write may lower a request or move an enable, and both are quiet when reset is released
    // ------------------------------------------------------------
    ovf_irq_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(irq_overflow) |-> $past(psel && penable && pwrite))
        else $error("overflow request dropped without write");
    ch_irq_fall_a: assert property (@(posedge pclk) disable iff (!presetn)
        |($past(irq_channel) & ~irq_channel) |-> $past(psel && penable && pwrite))
        else $error("channel request dropped without write");
    oe_cfg_a: assert property (@(posedge pclk) disable iff (!presetn)
        $changed(ch_oe) |-> $past(psel && penable && pwrite))
        else $error("pin enable moved without write");
    reset_quiet_a: assert property (@(posedge pclk)
        $rose(presetn) |-> ch_oe == 2'b00 && !irq_overflow && irq_channel == 2'b00)
        else $error("outputs active after reset");
endmodule
bind tef_top tef_chk tef_chk_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ch_oe(ch_oe), .irq_overflow(irq_overflow),
    .irq_channel(irq_channel));

// ### tb/tef_irq_sink.sv
// Interrupt-controller model that counts new overflow and channel requests.
`timescale 1ns/1ps
module tef_irq_sink (
    // Clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Level requests from the timer
    input  wire logic       irq_overflow,
    input  wire logic [1:0] irq_channel,
    // Count of rising overflow requests
    output logic      [7:0] ovf_rises_q,
    // Count of cycles in which a channel request rose
    output logic      [7:0] ch_rises_q
);
    logic       ovf_q;
    logic [7:0] ovf_rises_d;
    logic [7:0] ch_rises_d;
    logic [1:0] ch_q;
    // A static level is counted once, when it was low a cycle before.
    always_comb begin
        ovf_rises_d = ovf_rises_q + ((irq_overflow && !ovf_q) ? 8'h01 : 8'h00);
        ch_rises_d  = ch_rises_q + ((|(irq_channel & ~ch_q)) ? 8'h01 : 8'h00);
    end
    // Levels of the previous cycle feed the rise counters.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_q       <= 1'b0;
            ch_q        <= 2'b00;
            ovf_rises_q <= 8'h00;
            ch_rises_q  <= 8'h00;
        end else begin
            ovf_q       <= irq_overflow;
            ch_q        <= irq_channel;
            ovf_rises_q <= ovf_rises_d;
            ch_rises_q  <= ch_rises_d;
        end
    end
endmodule
